// File: verification/host_model.sv
// host-side model: drives the control pins and resolves the open-drain fault line
`timescale 1ns/1ps
module host_model (
   // commands from the bench
   input  wire logic       sleep_cmd,
   input  wire logic [2:0] enable_cmd,
   input  wire logic [2:0] drive_cmd,
   // pins toward the device
   output logic            sleep_n,
   output logic [2:0]      phase_enable,
   output logic [2:0]      phase_drive_in,
   // open-drain fault pin
   input  wire logic       fault_flag_n_out,
   input  wire logic       fault_flag_n_oe,
   output logic            fault_line
);
   // sleep_n is always driven, never left to the internal pull-down
   assign sleep_n        = sleep_cmd;
   assign phase_enable   = enable_cmd;
   assign phase_drive_in = drive_cmd;
   // the board pull-up wins whenever the device lets go of the pin
   assign fault_line     = fault_flag_n_oe ? fault_flag_n_out : 1'b1;
endmodule : host_model

// File: verification/three_phase_gate_drive_control_bench.sv
// self-checking bench for the three-phase gate drive control block
`timescale 1ns/1ps
module three_phase_gate_drive_control_bench;
   // short counts keep the run brief
   localparam int PW = 20;
   localparam int LP = 4;
   localparam int BL = 6;
   localparam int DT = 2;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        sleep_cmd = 1'b1;
   logic [2:0]  enable_cmd = 3'h0;
   logic [2:0]  drive_cmd = 3'h0;
   logic        gate_supply_good = 1'b1;
   logic [5:0]  drain_source_trip = 6'h00;
   logic        shunt_sense = 1'b0;
   logic        protect_disable = 1'b0;
   logic        sleep_n;
   logic        fault_line;
   logic        fault_flag_n_out;
   logic        fault_flag_n_oe;
   logic [2:0]  phase_enable;
   logic [2:0]  phase_drive_in;
   logic [2:0]  high_gate_out;
   logic [2:0]  low_gate_out;
   logic [31:0] seed = 32'h0000_7605;
   int          mismatches = 0;
   int          num_checks = 0;
   always #25 clk_sys = ~clk_sys;
   host_model host (.sleep_cmd(sleep_cmd), .enable_cmd(enable_cmd), .drive_cmd(drive_cmd), .sleep_n(sleep_n),
      .phase_enable(phase_enable), .phase_drive_in(phase_drive_in), .fault_flag_n_out(fault_flag_n_out),
      .fault_flag_n_oe(fault_flag_n_oe), .fault_line(fault_line));
   gate_drive_ctrl #(.PWRUP_CYCLES(PW), .LOW_PULSE(LP), .BLANK(BL), .DEAD(DT)) dut (.clk_sys(clk_sys), .rst(rst),
      .sleep_n(sleep_n), .phase_enable(phase_enable), .phase_drive_in(phase_drive_in),
      .gate_supply_good(gate_supply_good), .drain_source_trip(drain_source_trip), .shunt_sense(shunt_sense),
      .protect_disable(protect_disable), .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
      .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe));
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick
   task automatic wrap_up;
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic void roll();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
   endfunction : roll
   function automatic logic [6:0] snap();
      return {fault_flag_n_oe, high_gate_out, low_gate_out};
   endfunction : snap
   function automatic logic [6:0] running(input logic [2:0] en, input logic [2:0] drv);
      return {1'b0, en & drv, en & ~drv};
   endfunction : running
   // idx 0..2 are low gates, 3..5 high gates; gives up after bound cycles
   task automatic wait_gate(input int idx, input int bound);
      int n;
      logic [5:0] g;
      n = 0;
      g = {high_gate_out, low_gate_out};
      while (g[idx] !== 1'b1) begin
         if (n == bound) begin
            mismatches++;
            $display("wrong value at %0t: gate %0d never turned on", $time, idx);
            wrap_up();
         end
         tick(1);
         n++;
         g = {high_gate_out, low_gate_out};
      end
   endtask : wait_gate
   initial begin
      int i;
      tick(5);
      rst = 1'b0;
      enable_cmd = 3'h7;
      roll();
      drive_cmd = seed[2:0];
      tick(PW - 2);
      check(snap(), 7'h00);
      enable_cmd = 3'h0;
      tick(8);
      check(snap(), 7'h00);
      // each phase enabled in turn with drive high: low pulse first, high gate after dead time
      drive_cmd = 3'h7;
      for (i = 0; i < 3; i++) begin
         enable_cmd[i] = 1'b1;
         wait_gate(i, 6);
         check(snap(), {1'b0, enable_cmd & ~(3'h1 << i), 3'h1 << i});
         wait_gate(i + 3, LP + DT + 8);
         check(snap(), running(enable_cmd, drive_cmd));
      end
      for (i = 0; i < 20; i++) begin
         roll();
         drive_cmd = seed[2:0];
         tick(DT + 4);
         check(snap(), running(enable_cmd, drive_cmd));
      end
      enable_cmd = 3'h5;
      roll();
      drive_cmd = seed[2:0];
      tick(DT + 4);
      check(snap(), running(enable_cmd, drive_cmd));
      enable_cmd = 3'h7;
      tick(LP + DT + BL + 6);
      // a trip right after switching falls inside the blanking window
      drive_cmd = ~drive_cmd;
      tick(1);
      drain_source_trip = 6'h01;
      tick(2);
      drain_source_trip = 6'h00;
      tick(2);
      check({6'h00, fault_flag_n_oe}, 7'h00);
      tick(BL + DT + 6);
      roll();
      drain_source_trip = 6'h01 << (seed % 6);
      tick(3);
      check(snap(), 7'h40);
      drain_source_trip = 6'h00;
      enable_cmd = 3'h0;
      tick(4);
      check(snap(), 7'h40);
      check({6'h00, fault_line}, 7'h00);
      sleep_cmd = 1'b0;
      enable_cmd = 3'h7;
      tick(3);
      check(snap(), 7'h00);
      check({6'h00, fault_line}, 7'h01);
      sleep_cmd = 1'b1;
      tick(PW - 2);
      check(snap(), 7'h00);
      enable_cmd = 3'h0;
      tick(8);
      protect_disable = 1'b1;
      shunt_sense = 1'b1;
      tick(4);
      check({6'h00, fault_flag_n_oe}, 7'h00);
      protect_disable = 1'b0;
      tick(3);
      check(snap(), 7'h40);
      shunt_sense = 1'b0;
      rst = 1'b1;
      tick(2);
      check(snap(), 7'h00);
      // supply not good: power-up never completes
      gate_supply_good = 1'b0;
      rst = 1'b0;
      enable_cmd = 3'h7;
      tick(PW + 10);
      check(snap(), 7'h00);
      enable_cmd = 3'h0;
      gate_supply_good = 1'b1;
      drive_cmd = 3'h0;
      tick(4);
      enable_cmd = 3'h1;
      wait_gate(0, PW + 12);
      gate_supply_good = 1'b0;
      tick(3);
      check(snap(), 7'h40);
      wrap_up();
   end
endmodule : three_phase_gate_drive_control_bench

// File: verilog/gate_drive_ctrl.sv
// three-phase gate drive control: power-up, sleep, faults, blanking
`timescale 1ns/1ps
`include "gate_drive_defs.svh"
module gate_drive_ctrl
   import gate_drive_pkg::*;
#(
   parameter int PWRUP_CYCLES = `PWRUP_CYCLES,
   parameter int LOW_PULSE    = `LOW_PULSE_CYCLES,
   parameter int BLANK        = `BLANK_CYCLES,
   parameter int DEAD         = `DEAD_CYCLES
) (
   // clock and reset (reset is tied to supply lockout)
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // host inputs
   input  wire logic       sleep_n,
   input  wire logic [2:0] phase_enable,
   input  wire logic [2:0] phase_drive_in,
   // analog monitors and protection strap
   input  wire logic       gate_supply_good,
   input  wire logic [5:0] drain_source_trip,
   input  wire logic       shunt_sense,
   input  wire logic       protect_disable,
   // gate commands
   output logic [2:0]      high_gate_out,
   output logic [2:0]      low_gate_out,
   // open-drain fault pin
   output logic            fault_flag_n_out,
   output logic            fault_flag_n_oe
);
   localparam int CW = $clog2(PWRUP_CYCLES + 1);
   localparam int BW = $clog2(BLANK + 1);

   drive_state_e  state;
   drive_state_e  next_state;
   logic [CW-1:0] pwr_cnt;
   logic [CW-1:0] next_pwr_cnt;
   logic [BW-1:0] blank_cnt;
   logic [BW-1:0] next_blank_cnt;
   logic          supply_seen;
   logic          next_supply_seen;
   logic          fault_flag;
   logic          next_fault_flag;
   logic          run;
   logic          vds_trip;
   logic          over_trip;
   logic [2:0]    switched;

   assign run = (state == ST_RUN);
   // drain-source trips are masked while a recent switching edge is blanked
   assign vds_trip  = (|drain_source_trip) && blank_cnt == '0 && !protect_disable;
   assign over_trip = shunt_sense && !protect_disable;

   always_comb begin
      next_state       = state;
      next_pwr_cnt     = pwr_cnt;
      next_supply_seen = supply_seen;
      next_fault_flag  = 1'b0;
      next_blank_cnt   = (|switched) ? BW'(BLANK) :
                         (blank_cnt != '0) ? blank_cnt - BW'(1) : blank_cnt;
      if (!sleep_n) begin
         next_state       = ST_OFF;
         next_pwr_cnt     = '0;
         next_supply_seen = 1'b0;
      end else begin
         unique case (state)
            ST_OFF: begin
               next_state   = ST_PWRUP;
               next_pwr_cnt = '0;
            end
            ST_PWRUP: begin
               if (gate_supply_good) begin
                  next_supply_seen = 1'b1;
               end
               if (pwr_cnt < CW'(PWRUP_CYCLES)) begin
                  next_pwr_cnt = pwr_cnt + CW'(1);
               end else if (supply_seen && gate_supply_good) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (vds_trip || over_trip || !gate_supply_good) begin
                  next_state      = ST_FAULT;
                  next_fault_flag = 1'b1;
               end
            end
            ST_FAULT: begin
               next_fault_flag = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state       <= ST_OFF;
         pwr_cnt     <= '0;
         blank_cnt   <= '0;
         supply_seen <= 1'b0;
         fault_flag  <= 1'b0;
      end else begin
         state       <= next_state;
         pwr_cnt     <= next_pwr_cnt;
         blank_cnt   <= next_blank_cnt;
         supply_seen <= next_supply_seen;
         fault_flag  <= next_fault_flag;
      end
   end

   for (genvar p = 0; p < 3; p++) begin : g_leg
      phase_leg #(
         .LOW_PULSE (LOW_PULSE),
         .DEAD      (DEAD)
      ) u_leg (
         .clk_sys        (clk_sys),
         .rst            (rst),
         .run            (run && next_state == ST_RUN),
         .phase_enable   (phase_enable[p]),
         .phase_drive_in (phase_drive_in[p]),
         .high_gate_out  (high_gate_out[p]),
         .low_gate_out   (low_gate_out[p]),
         .switched       (switched[p])
      );
   end

   // open-drain: only ever pulls low
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe  = fault_flag;

   sequence fault_cause_s;
      run && (vds_trip || over_trip || !gate_supply_good) && sleep_n;
   endsequence
   fault_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
      fault_cause_s |=> state == ST_FAULT && fault_flag_n_oe) else $error("trip did not latch fault");
   gates_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      fault_cause_s |=> ##1 (high_gate_out == 3'h0 && low_gate_out == 3'h0)) else $error("gates on after trip");
   fault_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_FAULT && sleep_n |=> state == ST_FAULT) else $error("fault latch released");
   sleep_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      !sleep_n |=> state == ST_OFF && !fault_flag_n_oe) else $error("sleep did not clear");
   wake_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(sleep_n) |=> state == ST_PWRUP) else $error("wake skipped power-up");
   pwrup_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_PWRUP && $past(state) != ST_PWRUP |-> !run [*8]) else $error("ran too early");
   run_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(run) |-> $past(pwr_cnt) == CW'(PWRUP_CYCLES) && supply_seen) else $error("run entered early");
   blank_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      (|switched) && run |=> !vds_trip) else $error("trip not blanked");
   shunt_trip_a: assert property (@(posedge clk_sys) disable iff (rst)
      run && sleep_n && shunt_sense && !protect_disable |=> state == ST_FAULT) else $error("shunt trip missed");
   protect_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      run && sleep_n && protect_disable && gate_supply_good |=> state == ST_RUN) else $error("disabled trip acted");

   // invariants of the state machine, the gates, the trips, the blanking counter and the fault pin
   sequence supply_loss_s;
      run && sleep_n && !gate_supply_good;
   endsequence

   sequence pwrup_counting_s;
      state == ST_PWRUP && sleep_n && pwr_cnt != CW'(PWRUP_CYCLES);
   endsequence

   oe_reset_a: assert property (@(posedge clk_sys)
      rst |=> state == ST_OFF && !fault_flag_n_oe && high_gate_out == 3'h0 && low_gate_out == 3'h0)
      else $error("reset left logic active");

   idle_gates_a: assert property (@(posedge clk_sys) disable iff (rst)
      state != ST_RUN |-> high_gate_out == 3'h0 && low_gate_out == 3'h0)
      else $error("gate on outside run");

   sleep_gates_a: assert property (@(posedge clk_sys) disable iff (rst)
      !sleep_n |=> high_gate_out == 3'h0 && low_gate_out == 3'h0)
      else $error("gate on in sleep");

   off_wake_a: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_OFF && sleep_n |=> state == ST_PWRUP)
      else $error("wake did not start power-up");

   supply_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_PWRUP && !supply_seen |=> state != ST_RUN)
      else $error("run without supply seen");

   pwrup_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      pwrup_counting_s |=> state == ST_PWRUP)
      else $error("power-up cut short");

   supply_loss_a: assert property (@(posedge clk_sys) disable iff (rst)
      supply_loss_s |=> state == ST_FAULT && fault_flag_n_oe)
      else $error("supply loss not latched");

   oe_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
      fault_flag_n_oe == (state == ST_FAULT))
      else $error("fault pin disagrees with state");

   pin_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      fault_flag_n_oe |-> fault_flag_n_out == 1'b0)
      else $error("fault pin drives high");

   blank_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      (|switched) |=> blank_cnt == BW'(BLANK))
      else $error("blanking not restarted");

   strap_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      protect_disable |-> !vds_trip && !over_trip)
      else $error("strap did not mask trips");

   run_stays_a: assert property (@(posedge clk_sys) disable iff (rst)
      run && sleep_n && !vds_trip && !over_trip && gate_supply_good |=> run)
      else $error("run dropped without cause");

   vds_trip_a: assert property (@(posedge clk_sys) disable iff (rst)
      run && sleep_n && vds_trip |=> high_gate_out == 3'h0 && low_gate_out == 3'h0)
      else $error("gates on after drain-source trip");
endmodule : gate_drive_ctrl

// File: verilog/gate_drive_defs.svh
// constants for the three-phase gate drive control block
`ifndef GATE_DRIVE_DEFS_SVH
`define GATE_DRIVE_DEFS_SVH

`define CLK_PERIOD_NS     50
`define PWRUP_MIN_US      1000
`define PWRUP_MAX_US      2000
// least time rounds up; 1 ms at 50 ns is exactly 20000 cycles
`define PWRUP_CYCLES      ((`PWRUP_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_PULSE_CYCLES  16
`define BLANK_CYCLES      20
`define DEAD_CYCLES       4

`endif

// File: verilog/gate_drive_pkg.sv
// types shared by the gate drive control block
package gate_drive_pkg;
   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_PWRUP = 2'b01,
      ST_RUN   = 2'b10,
      ST_FAULT = 2'b11
   } drive_state_e;
endpackage : gate_drive_pkg

// File: verilog/phase_leg.sv
// one half-bridge leg: enable decode, low-side pulse and dead time
`timescale 1ns/1ps
`include "gate_drive_defs.svh"
module phase_leg #(
   // pulse and dead time are counts of clk_sys cycles, tuned per board
   parameter int LOW_PULSE = `LOW_PULSE_CYCLES,
   parameter int DEAD      = `DEAD_CYCLES
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // control
   input  wire logic run,
   input  wire logic phase_enable,
   input  wire logic phase_drive_in,
   // gate commands and switch flag
   output logic      high_gate_out,
   output logic      low_gate_out,
   output logic      switched
);
   localparam int PW = $clog2(LOW_PULSE + 1);
   localparam int DW = $clog2(DEAD + 1);

   logic          en_prev;
   logic [PW-1:0] pulse_cnt;
   logic [DW-1:0] dead_cnt;
   logic          next_en_prev;
   logic [PW-1:0] next_pulse_cnt;
   logic [DW-1:0] next_dead_cnt;
   logic          next_high;
   logic          next_low;
   logic          want_high;
   logic          want_low;

   always_comb begin
      next_en_prev   = run & phase_enable;
      next_pulse_cnt = pulse_cnt;
      next_dead_cnt  = dead_cnt;
      want_high      = 1'b0;
      want_low       = 1'b0;
      if (!run) begin
         next_pulse_cnt = '0;
      end else if (phase_enable && !en_prev) begin
         next_pulse_cnt = PW'(LOW_PULSE);
      end else if (pulse_cnt != '0) begin
         next_pulse_cnt = pulse_cnt - PW'(1);
      end
      if (run && phase_enable) begin
         if (next_pulse_cnt != '0) begin
            want_low = 1'b1;
         end else begin
            want_high = phase_drive_in;
            want_low  = ~phase_drive_in;
         end
      end
      // a gate may turn on only once both were off for the dead time
      next_high = want_high & high_gate_out;
      next_low  = want_low & low_gate_out;
      if (high_gate_out || low_gate_out) begin
         next_dead_cnt = DW'(DEAD);
      end else if (dead_cnt != '0) begin
         next_dead_cnt = dead_cnt - DW'(1);
      end
      if (!high_gate_out && !low_gate_out && dead_cnt == '0) begin
         next_high = want_high;
         next_low  = want_low;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_prev       <= 1'b0;
         pulse_cnt     <= '0;
         dead_cnt      <= '0;
         high_gate_out <= 1'b0;
         low_gate_out  <= 1'b0;
      end else begin
         en_prev       <= next_en_prev;
         pulse_cnt     <= next_pulse_cnt;
         dead_cnt      <= next_dead_cnt;
         high_gate_out <= next_high;
         low_gate_out  <= next_low;
      end
   end

   assign switched = (next_high != high_gate_out) | (next_low != low_gate_out);

   never_both_a: assert property (@(posedge clk_sys) disable iff (rst)
      !(high_gate_out && low_gate_out)) else $error("both gates of a leg on");
   dead_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(low_gate_out) |-> !high_gate_out [*2]) else $error("no dead time after low gate off");
   disabled_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      !phase_enable |=> !high_gate_out && !low_gate_out) else $error("disabled leg drives a gate");
   enable_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      (run && phase_enable && !en_prev && !high_gate_out && dead_cnt == '0) ##1 (run && phase_enable) [*3]
      |-> !high_gate_out) else $error("high gate on during enable pulse");
endmodule : phase_leg
